//--- logic/osd_diag_core.sv
// Operation
// - fault output pulled low as soon as any channel reports an error
// - channel faults latch into the diagnosis register until cleared
// - serial data output released while chip select is high
// - while chip select low, all diagnosis bits shift out serially
// - rising chip select clears all latched error bits
// - no fault reports the command bit; fault reports its inverse
// - channel off with drain below threshold reports high (here only while program pin is high)
// - channels 1-4 on by parallel input only: high is fault
// - serial bit high on channels 1-4: encode against serial bit
// - channels 1-4 on when parallel input or serial bit is high
// - open-load pull-downs enabled while program pin is high
// - falling chip select loads diagnostic status into shift register
// - bits leave msb first, changing after each serial clock rise
// - diagnostic bit n belongs to channel n+1, bit 7 first
module osd_diag_core
  import osd_pkg::*;
#(
  parameter int CHANNELS = OSD_CHANNELS,
  parameter int PAR_CHANNELS = OSD_PAR_CHANNELS
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic si_pin,
  input wire logic [PAR_CHANNELS-1:0] parallel_on_pin,
  input wire logic [CHANNELS-1:0] drain_high_pin,
  input wire logic [CHANNELS-1:0] overload_pin,
  input wire logic open_load_detect_enable_pin,
  output logic so_out,
  output logic so_oe,
  output logic fault_n_out,
  output logic fault_n_oe,
  output logic [CHANNELS-1:0] channel_on,
  output logic open_load_sink_enable
);
  osd_sync_if sync ();

  logic [PAR_CHANNELS-1:0] par_s1_reg;
  logic [PAR_CHANNELS-1:0] par_s2_reg;
  logic [CHANNELS-1:0] drain_s1_reg;
  logic [CHANNELS-1:0] drain_s2_reg;
  logic [CHANNELS-1:0] ovl_s1_reg;
  logic [CHANNELS-1:0] ovl_s2_reg;
  logic ol_s1_reg;
  logic ol_s2_reg;

  logic [CHANNELS-1:0] cmd_reg;
  logic [CHANNELS-1:0] cmd_next;
  logic [CHANNELS-1:0] in_shift_reg;
  logic [CHANNELS-1:0] in_shift_next;
  logic [CHANNELS-1:0] out_shift_reg;
  logic [CHANNELS-1:0] out_shift_next;
  logic [CHANNELS-1:0] err_reg;
  logic [CHANNELS-1:0] err_next;
  logic so_reg;
  logic so_next;
  logic so_oe_reg;
  logic fault_n_reg;
  logic [CHANNELS-1:0] on_reg;

  wire [CHANNELS-1:0] par_ext;
  wire [CHANNELS-1:0] on_now;
  wire [CHANNELS-1:0] fault_now;
  wire [CHANNELS-1:0] diag_word;
  wire [CHANNELS-1:0] off_low;
  wire [CHANNELS-1:0] on_high;
  wire sck_rise_sel;
  wire sck_fall_sel;
  wire frame_full;
  wire cmd_load;

  // frame progress: idle until the first sck fall, full after a word
  typedef enum logic [1:0] {
    OSD_FRAME_IDLE,
    OSD_FRAME_SHIFT,
    OSD_FRAME_FULL
  } osd_frame_type;

  osd_frame_type frame_reg;
  osd_frame_type frame_next;
  logic [3:0] bit_count_reg;
  logic [3:0] bit_count_next;

  // one left shift with a new lsb, shared by the command and diagnostic
  // shifters so both agree on msb-first order
  function automatic logic [CHANNELS-1:0] shift_up(
    input logic [CHANNELS-1:0] word,
    input logic bit_in
  );
    shift_up = {word[CHANNELS-2:0], bit_in};
  endfunction

  // saturating bit counter step; a run of extra clocks cannot wrap it
  function automatic logic [3:0] count_up(input logic [3:0] count);
    count_up = (count == OSD_BITCNT_LAST) ? count : 4'(count + 4'h1);
  endfunction

  osd_pin_sampler u_sampler (
    .clk(clk),
    .reset_n(reset_n),
    .cs_n_pin(cs_n_pin),
    .sck_pin(sck_pin),
    .si_pin(si_pin),
    .sync(sync)
  );

  // status pins come from the analog side, so they are synchronised too;
  // this first stage may go metastable, so only the second stage reads it
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      par_s1_reg <= '0;
      drain_s1_reg <= '0;
      ovl_s1_reg <= '0;
      ol_s1_reg <= 1'b1;
    end
    else
    begin
      par_s1_reg <= parallel_on_pin;
      drain_s1_reg <= drain_high_pin;
      ovl_s1_reg <= overload_pin;
      ol_s1_reg <= open_load_detect_enable_pin;
    end
  end

  // second stage; the program pin resets high to match its pull-up
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      par_s2_reg <= '0;
      drain_s2_reg <= '0;
      ovl_s2_reg <= '0;
      ol_s2_reg <= 1'b1;
    end
    else
    begin
      par_s2_reg <= par_s1_reg;
      drain_s2_reg <= drain_s1_reg;
      ovl_s2_reg <= ovl_s1_reg;
      ol_s2_reg <= ol_s1_reg;
    end
  end

  // parallel control only exists on the low channels
  assign par_ext = {{(CHANNELS-PAR_CHANNELS){1'b0}}, par_s2_reg};
  assign on_now = cmd_reg | par_ext;

  // drain sensing: off and low means open load or short to ground,
  // which is only visible while the pull-downs are enabled
  assign off_low = ~on_now & ~drain_s2_reg &
    {CHANNELS{ol_s2_reg}};
  assign on_high = on_now & (drain_s2_reg | ovl_s2_reg);
  assign fault_now = off_low | on_high;

  // diagnostic encoding: command bit, inverted when the channel faulted.
  // a low serial bit means the parallel-only case reads high on fault.
  assign diag_word = cmd_reg ^ err_reg;

  // serial clock edges only count while the device is selected
  assign sck_rise_sel = sync.sck_rise & ~sync.cs_n_level;
  assign sck_fall_sel = sync.sck_fall & ~sync.cs_n_level;
  assign frame_full = (frame_reg == OSD_FRAME_FULL);
  // a cut frame leaves a part word in the shifter, so it never loads
  assign cmd_load = sync.cs_rise & frame_full;

  // serial command capture on falling sck, msb first
  assign in_shift_next = sck_fall_sel ?
    shift_up(in_shift_reg, sync.si_level) : in_shift_reg;
  assign cmd_next = cmd_load ? in_shift_reg : cmd_reg;

  // error latch: new faults win over the clear on the same edge
  assign err_next = (sync.cs_rise ? '0 : err_reg) | fault_now;

  // diagnostic shifter: load at select fall, shift after sck rise
  assign out_shift_next = sync.cs_fall ? diag_word :
    sck_rise_sel ? shift_up(out_shift_reg, 1'b0) :
    out_shift_reg;
  assign so_next = sync.cs_fall ? diag_word[CHANNELS-1] :
    sck_rise_sel ? out_shift_reg[CHANNELS-2] : so_reg;

  // frame tracker; select edges restart it, so each frame counts afresh
  always_comb
  begin
    frame_next = frame_reg;
    bit_count_next = bit_count_reg;
    if (sync.cs_fall || sync.cs_rise)
    begin
      frame_next = OSD_FRAME_IDLE;
      bit_count_next = OSD_BITCNT_RESET;
    end
    else if (sck_fall_sel)
    begin
      case (frame_reg)
        OSD_FRAME_IDLE:
        begin
          frame_next = OSD_FRAME_SHIFT;
          bit_count_next = OSD_BITCNT_RESET;
        end
        OSD_FRAME_SHIFT:
        begin
          bit_count_next = count_up(bit_count_reg);
          if (bit_count_next == OSD_BITCNT_LAST)
          begin
            frame_next = OSD_FRAME_FULL;
          end
        end
        OSD_FRAME_FULL:
        begin
          frame_next = OSD_FRAME_FULL; // extra bits keep the last word
        end
        default:
        begin
          frame_next = OSD_FRAME_IDLE;
          bit_count_next = OSD_BITCNT_RESET;
        end
      endcase
    end
  end

  // frame state registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      frame_reg <= OSD_FRAME_IDLE;
      bit_count_reg <= OSD_BITCNT_RESET;
    end
    else
    begin
      frame_reg <= frame_next;
      bit_count_reg <= bit_count_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      in_shift_reg <= OSD_CMD_RESET;
      cmd_reg <= OSD_CMD_RESET;
      err_reg <= OSD_DIAG_RESET;
      out_shift_reg <= OSD_DIAG_RESET;
      so_reg <= 1'b0;
    end
    else
    begin
      in_shift_reg <= in_shift_next;
      cmd_reg <= cmd_next;
      err_reg <= err_next;
      out_shift_reg <= out_shift_next;
      so_reg <= so_next;
    end
  end

  // serial output enable, one clock behind the synced select level
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      so_oe_reg <= 1'b0;
    end
    else
    begin
      so_oe_reg <= ~sync.cs_n_level;
    end
  end

  // fault flag follows the next error word, so a set is never missed
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      fault_n_reg <= 1'b1;
    end
    else
    begin
      fault_n_reg <= ~(|err_next);
    end
  end

  // channel drive; registered so a pin change cannot glitch the load
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      on_reg <= '0;
    end
    else
    begin
      on_reg <= on_now;
    end
  end

  assign so_out = so_reg;
  assign so_oe = so_oe_reg;
  // open drain: only ever drives low
  assign fault_n_out = 1'b0;
  assign fault_n_oe = ~fault_n_reg;
  assign channel_on = on_reg;
  assign open_load_sink_enable = ol_s2_reg;
endmodule // osd_diag_core

//--- logic/osd_pkg.sv
package osd_pkg;
  localparam int OSD_CHANNELS = 8;
  localparam int OSD_PAR_CHANNELS = 4;
  localparam logic [7:0] OSD_CMD_RESET = 8'h00;
  localparam logic [7:0] OSD_DIAG_RESET = 8'h00;
  localparam logic [3:0] OSD_BITCNT_RESET = 4'h0;
  localparam logic [3:0] OSD_BITCNT_LAST = 4'h7;
endpackage

//--- logic/osd_sync_if.sv
// synchronised serial pins and edge strobes between sampler and core
interface osd_sync_if;
  logic cs_n_level;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic si_level;
  modport sampler (output cs_n_level, cs_fall, cs_rise, sck_rise,
    sck_fall, si_level);
  modport core (input cs_n_level, cs_fall, cs_rise, sck_rise,
    sck_fall, si_level);
endinterface

//--- logic/osd_pin_sampler.sv
// two-flop sampling of serial pins plus edge detection on the third stage
module osd_pin_sampler
  import osd_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic si_pin,
  osd_sync_if.sampler sync
);
  logic [2:0] cs_reg;
  logic [2:0] sck_reg;
  logic [1:0] si_reg;

  // shift chains; only stage 1 and later are read by logic
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cs_reg <= 3'h7;
      sck_reg <= 3'h0;
      si_reg <= 2'h0;
    end
    else
    begin
      cs_reg <= {cs_reg[1:0], cs_n_pin};
      sck_reg <= {sck_reg[1:0], sck_pin};
      si_reg <= {si_reg[0], si_pin};
    end
  end

  assign sync.cs_n_level = cs_reg[1];
  assign sync.cs_fall = cs_reg[2] & ~cs_reg[1];
  assign sync.cs_rise = ~cs_reg[2] & cs_reg[1];
  assign sync.sck_rise = ~sck_reg[2] & sck_reg[1];
  assign sync.sck_fall = sck_reg[2] & ~sck_reg[1];
  assign sync.si_level = si_reg[1];
endmodule // osd_pin_sampler

//--- bench/osd_props.sv
module osd_props (
  input logic clk,
  input logic reset_n,
  input logic cs_n_pin,
  input logic [3:0] parallel_on_pin,
  input logic [7:0] overload_pin,
  input logic open_load_detect_enable_pin,
  input logic so_oe,
  input logic fault_n_out,
  input logic fault_n_oe,
  input logic [7:0] channel_on,
  input logic open_load_sink_enable
);
  timeunit 1ns / 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // pins cross two flops first, so each window allows some lag
  a_so_off: assert property (cs_n_pin [*8] |-> !so_oe)
    else $error("so not released");
  a_so_load: assert property ($fell(cs_n_pin) |-> ##[2:8] so_oe)
    else $error("so late");
  a_so_on: assert property (!cs_n_pin [*8] |-> so_oe)
    else $error("so off in frame");
  a_flag_set: assert property ((|(overload_pin & channel_on)) [*8]
    |-> fault_n_oe) else $error("no fault flag");
  a_flag_hold: assert property ((fault_n_oe && cs_n_pin) [*8]
    |=> fault_n_oe) else $error("fault flag lost");
  a_sink_on: assert property (open_load_detect_enable_pin [*4]
    |-> open_load_sink_enable) else $error("sinks off");
  a_par_on: assert property ((&parallel_on_pin) [*6]
    |-> &channel_on[3:0]) else $error("channel off");
  a_ol_off: assert property (!open_load_detect_enable_pin [*4]
    |-> !open_load_sink_enable) else $error("sinks on");
  c_flag_up: cover property ($rose(fault_n_oe));
  c_flag_down: cover property ($fell(fault_n_oe));
  c_frame: cover property ($fell(so_oe));
endmodule // osd_props
bind osd_diag_core osd_props i_osd_props (.*);

//--- bench/osd_master.sv
module osd_master (
  input logic clk,
  input logic so_out,
  input logic so_oe,
  output logic cs_n_pin = 1'b1,
  output logic sck_pin = 1'b0,
  output logic si_pin = 1'b0
);
  timeunit 1ns / 100ps;
  // one frame msb first, 48 ns clock idling low at select edges
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    @(negedge clk) #48.3 cs_n_pin = 1'b0;
    #24;
    for (int i = 7; i >= 0; i--)
    begin
      #24 rx[i] = so_oe ? so_out : 1'bx;
      {sck_pin, si_pin} = {1'b1, tx[i]};
      #24 sck_pin = 1'b0;
    end
    #24 {cs_n_pin, si_pin} = {1'b1, ~si_pin}; // no stale data
  endtask
endmodule // osd_master

//--- bench/tb_top.sv
module tb_top;
  timeunit 1ns / 100ps;
  logic clk = 1'b0, reset_n = 1'b0, open_load_detect_enable_pin = 1'b1;
  logic [3:0] parallel_on_pin = 4'h0;
  logic [7:0] drain_high_pin = 8'h5a, overload_pin = 8'h00, channel_on, rx;
  logic cs_n_pin, sck_pin, si_pin, so_out, so_oe, fault_n_out, fault_n_oe;
  logic open_load_sink_enable;
  int num_errors = 0, total_checks = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  osd_master i_osd_master (
    .clk(clk),
    .so_out(so_out),
    .so_oe(so_oe),
    .cs_n_pin(cs_n_pin),
    .sck_pin(sck_pin),
    .si_pin(si_pin)
  );
  osd_diag_core i_osd_diag_core (
    .clk(clk),
    .reset_n(reset_n),
    .cs_n_pin(cs_n_pin),
    .sck_pin(sck_pin),
    .si_pin(si_pin),
    .parallel_on_pin(parallel_on_pin),
    .drain_high_pin(drain_high_pin),
    .overload_pin(overload_pin),
    .open_load_detect_enable_pin(open_load_detect_enable_pin),
    .so_out(so_out),
    .so_oe(so_oe),
    .fault_n_out(fault_n_out),
    .fault_n_oe(fault_n_oe),
    .channel_on(channel_on),
    .open_load_sink_enable(open_load_sink_enable)
  );
  task automatic chk(input logic [7:0] got, exp);
    total_checks++;
    num_errors += int'(got !== exp);
    if (got !== exp)
      $display("unexpected %0t got %h exp %h", $time, got, exp);
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rd(input logic [7:0] cmd, exp);
    repeat (3) i_osd_master.xfer(cmd, rx); // resend to read back
    repeat (6) @(negedge clk); // select rise takes a few clocks to land
    chk(rx, exp);
  endtask
  // overload latches, outlives its cause, clears on select rise
  task automatic t_fault();
    rd(8'ha5, 8'ha5);
    @(negedge clk) overload_pin = 8'h01;
    rd(8'ha5, 8'ha4);
    @(negedge clk) overload_pin = 8'h00;
    repeat (12) @(negedge clk);
    chk({7'h0, fault_n_oe}, 8'h01);
    chk({7'h0, fault_n_out}, 8'h00);
    rd(8'ha5, 8'ha5);
    chk({6'h0, fault_n_oe, so_oe}, 8'h00);
  endtask
  // open load needs the sinks; parallel-only channels flip polarity
  task automatic t_load();
    @(negedge clk) drain_high_pin = 8'h58;
    rd(8'ha5, 8'ha7);
    @(negedge clk) open_load_detect_enable_pin = 1'b0;
    rd(8'ha5, 8'ha5);
    @(negedge clk) {parallel_on_pin, drain_high_pin} = {4'hf, 8'h50};
    rd(8'ha5, 8'ha5);
    chk(channel_on, 8'haf);
    @(negedge clk) overload_pin = 8'h03;
    rd(8'ha5, 8'ha6);
  endtask
  // hold reset, then run the scenarios
  initial
  begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    t_fault();
    t_load();
    end_of_test();
  end
endmodule // tb_top
